// ### include/pprx_if.sv
// Purpose: carries control and status between receiver core and register file
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface pprx_if;
    import pprx_pkg::*;
    logic [CTRL_W-1:0] ctrl;
    logic [ST_W-1:0] status;
    logic [BYTE_W-1:0] last_byte;
    logic [CNT_W-1:0] count;
    modport regs (output ctrl, input status, input last_byte, input count);
    modport core (input ctrl, output status, output last_byte, output count);
endinterface

// ### include/pprx_pkg.sv
// Purpose: shared constants and types of the parallel print data receiver
// Assumes: 125 MHz core clock, AXI4-Lite register access
// Notes: register offsets are byte addresses of aligned 32-bit words
package pprx_pkg;
    localparam int CLK_MHZ = 125;
    localparam int BYTE_W = 8;
    // acknowledge low time in ns and its cycle count
    localparam int ACK_NS = 10000;
    localparam int ACK_CYC = (ACK_NS * CLK_MHZ) / 1000;
    localparam int ACK_CW = 12;
    // cycles after reset release before the mode pins are sampled
    localparam logic [1:0] PWR_SAMPLE_AT = 2'h3;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_DATA = 4'h8;
    localparam logic [ADDR_W-1:0] REG_COUNT = 4'hC;
    localparam int CTRL_W = 3;
    localparam int CTRL_AF_POL = 0;
    localparam int CTRL_SI_POL = 1;
    localparam int CTRL_OFFL = 2;
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h2;
    localparam int ST_W = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_ACK = 1;
    localparam int ST_PAPER = 2;
    localparam int ST_ERR = 3;
    localparam int ST_AUTOF = 4;
    localparam int ST_FLOW = 5;
    localparam int ST_INIT = 6;
    localparam int ST_PEND = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {S_IDLE, S_HAND, S_ACK} pprx_state_t;
endpackage

// ### sim/parallel_print_data_receiver_bench.sv
// Purpose: self-checking bench of the parallel print data receiver
// Assumes: small ack length, random buffer stalls from an xorshift source
// Notes: handover bytes are compared with a queue model, ack pulses with the set ack length
`timescale 1ns/1ps
module parallel_print_data_receiver_bench;
    import pprx_pkg::*;
    localparam int ACKC = 8;
    localparam int N_BYTES = 6;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    logic strobe_n;
    logic [7:0] pdata, rx_byte_out, last_b;
    logic init_n_in = 1'b1, autofeed_in = 1'b0, select_in_gate_in = 1'b1;
    logic offline_in = 1'b0, paper_out_in = 1'b0, fault_in = 1'b0, panel_init_in = 1'b0;
    logic rx_ready_in = 1'b0;
    logic byte_accepted_pulse_n_out, busy_out, paper_empty_flag_out, error_n_out;
    logic select_out_line_out, rx_valid_out, auto_feed_on_cr_out, flow_codes_enable_out;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0, ack_len = 0, n_acks = 0, n_rx = 0;
    logic [31:0] rng_q = 32'h4B4D;
    logic [7:0] exp_q[$];

    always #4 clk_in = ~clk_in;

    pprx_receiver #(.ACK_CYCLES(ACKC)) DUT (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .strobe_n_in(strobe_n), .parallel_byte_lines_in(pdata), .init_n_in(init_n_in),
        .autofeed_in(autofeed_in), .select_in_gate_in(select_in_gate_in),
        .byte_accepted_pulse_n_out(byte_accepted_pulse_n_out), .busy_out(busy_out),
        .paper_empty_flag_out(paper_empty_flag_out), .error_n_out(error_n_out),
        .select_out_line_out(select_out_line_out), .offline_in(offline_in),
        .paper_out_in(paper_out_in), .fault_in(fault_in), .panel_init_in(panel_init_in),
        .rx_byte_out(rx_byte_out), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
        .auto_feed_on_cr_out(auto_feed_on_cr_out),
        .flow_codes_enable_out(flow_codes_enable_out)
    );

    pprx_host_model host (.clk_in(clk_in), .busy_in(busy_out), .strobe_n_out(strobe_n),
        .data_out(pdata));

    function automatic logic [31:0] xs();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_d, w_d, seen, seen_w;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk_in);
            seen = awvalid && awready;
            seen_w = wvalid && wready;
            @(posedge clk_in);
            if (seen) awvalid <= 1'b0;
            aw_d = aw_d | seen;
            if (seen_w) wvalid <= 1'b0;
            w_d = w_d | seen_w;
        end while (!(aw_d && w_d));
        do @(negedge clk_in); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge clk_in);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk_in); while (arready !== 1'b1);
        @(posedge clk_in);
        arvalid <= 1'b0;
        do @(negedge clk_in); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge clk_in);
        rready <= 1'b0;
    endtask

    task automatic pulse_panel();
        @(posedge clk_in);
        panel_init_in <= 1'b1;
        @(posedge clk_in);
        panel_init_in <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    always @(posedge clk_in) begin
        rx_ready_in <= (xs() & 32'h3) != 32'h0;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // handover and ack pulse monitor, sampled mid-cycle
    always @(negedge clk_in) begin
        if (resetn_in && rx_valid_out === 1'b1 && rx_ready_in === 1'b1) begin
            check("rx_busy", busy_out, 32'h1);
            if (exp_q.size() == 0) check("rx_unexpected", 32'h1, 32'h0);
            else check("rx_byte", rx_byte_out, exp_q.pop_front());
            n_rx++;
        end
        if (resetn_in && byte_accepted_pulse_n_out === 1'b0) begin
            ack_len++;
            check("busy_in_ack", busy_out, 32'h1);
        end else if (ack_len != 0) begin
            check("ack_len", ack_len, ACKC);
            check("busy_after_ack", busy_out, 32'h0);
            n_acks++;
            ack_len = 0;
        end
    end

    initial begin
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        check("auto_feed", auto_feed_on_cr_out, 32'h1);
        check("flow", flow_codes_enable_out, 32'h1);
        axi_read(REG_CTRL, rd, rsp);
        check("ctrl_reset", rd, {29'h0, CTRL_RST});
        axi_read(REG_COUNT, rd, rsp);
        check("count_reset", rd, 32'h0);
        axi_read(REG_STATUS, rd, rsp);
        check("status_reset", rd, (32'h1 << ST_AUTOF) | (32'h1 << ST_FLOW));
        check("select_out", select_out_line_out, 32'h1);
        for (int i = 0; i < N_BYTES; i++) begin
            last_b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'(xs());
            exp_q.push_back(last_b);
            host.send_byte(last_b);
        end
        do @(negedge clk_in); while (busy_out !== 1'b0);
        check("ack_count", n_acks, N_BYTES);
        check("pending", exp_q.size(), 32'h0);
        axi_read(REG_DATA, rd, rsp);
        check("data_reg", rd, {24'h0, last_b});
        axi_read(REG_COUNT, rd, rsp);
        check("count_reg", rd, n_rx);
        init_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        host.send_byte(8'hA5);
        repeat (20) @(posedge clk_in);
        init_n_in <= 1'b1;
        check("init_ignored", n_rx, N_BYTES);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            {fault_in, paper_out_in, offline_in} <= i[2:0];
            @(negedge clk_in);
            check("busy_status", busy_out, (i != 0));
            check("paper_empty", paper_empty_flag_out, i[1]);
            check("error_n", error_n_out, (i == 0));
        end
        @(posedge clk_in);
        {fault_in, paper_out_in, offline_in} <= 3'h0;
        autofeed_in <= 1'b1;
        select_in_gate_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        check("auto_held", auto_feed_on_cr_out, 32'h1);
        pulse_panel();
        check("auto_panel", auto_feed_on_cr_out, 32'h0);
        check("flow_held", flow_codes_enable_out, 32'h1);
        axi_write(REG_CTRL, 32'h3, rsp);
        pulse_panel();
        check("auto_polarity", auto_feed_on_cr_out, 32'h1);
        axi_write(REG_CTRL, 32'h7, rsp);
        @(negedge clk_in);
        check("forced_busy", busy_out, 32'h1);
        axi_read(REG_CTRL, rd, rsp);
        check("ctrl_back", rd, 32'h7);
        axi_write(REG_CTRL, {29'h0, CTRL_RST}, rsp);
        check("write_resp", rsp, RESP_OKAY);
        axi_write(4'h2, 32'hFFFF_FFFF, rsp);
        check("unmapped_wr", rsp, RESP_SLVERR);
        axi_read(4'h2, rd, rsp);
        check("unmapped_rd", {rsp, rd[29:0]}, {RESP_SLVERR, 30'h0});
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        check("flow_reset", flow_codes_enable_out, 32'h0);
        check("auto_reset", auto_feed_on_cr_out, 32'h0);
        stop_test();
    end
endmodule

// ### sim/pprx_host_model.sv
// Purpose: host side model driving the strobed parallel print port
// Assumes: bench clock of 125 MHz, busy level from the receiver
// Notes: outside a transfer the data lines show the inverse of the last byte
`timescale 1ns/1ps
module pprx_host_model #(
    parameter int STB_CYC = 63
) (
    input wire logic clk_in,
    input wire logic busy_in,
    output logic strobe_n_out,
    output logic [pprx_pkg::BYTE_W-1:0] data_out
);
    import pprx_pkg::*;
    initial begin
        strobe_n_out = 1'b1;
        data_out = 8'h00;
    end
    // one byte: wait for busy low, set data, strobe low over 0.5 us
    task automatic send_byte(input logic [BYTE_W-1:0] b);
        do begin
            @(negedge clk_in);
        end while (busy_in !== 1'b0);
        @(posedge clk_in);
        data_out <= b;
        @(posedge clk_in);
        strobe_n_out <= 1'b0;
        repeat (STB_CYC) @(posedge clk_in);
        strobe_n_out <= 1'b1;
        @(posedge clk_in);
        data_out <= ~b;
    endtask
endmodule

// ### verilog/pprx_axil_regs.sv
// Purpose: AXI4-Lite slave holding control and reading back receiver state
// Assumes: one write and one read outstanding at most
// Notes: unmapped addresses answer SLVERR, reads of them return zero
`timescale 1ns/1ps
module pprx_axil_regs (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [pprx_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [pprx_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    pprx_if.regs rif
);
    import pprx_pkg::*;
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic do_write;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_DATA) ||
            (a == REG_COUNT);
    endfunction

    assign s_axi_awready_out = !aw_have_q && !bvalid_q;
    assign s_axi_wready_out = !w_have_q && !bvalid_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rdata_out = rdata_q;
    assign s_axi_rresp_out = rresp_q;
    assign rif.ctrl = ctrl_q;
    assign do_write = aw_have_q && w_have_q && !bvalid_q;

    // address and data may arrive in either order
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else if (bvalid_q && s_axi_bready_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata_in;
                wstrb0_q <= s_axi_wstrb_in[0];
            end
        end
    end

    // write response and control register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            ctrl_q <= CTRL_RST;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_q == REG_CTRL && wstrb0_q) begin
                ctrl_q <= wdata_q[CTRL_W-1:0];
            end
        end else if (s_axi_bready_in) begin
            bvalid_q <= 1'b0;
        end
    end

    // read path, answer registered on the same edge that takes the address
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr_in)
                REG_CTRL: rdata_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
                REG_STATUS: rdata_q <= {{(32-ST_W){1'b0}}, rif.status};
                REG_DATA: rdata_q <= {{(32-BYTE_W){1'b0}}, rif.last_byte};
                REG_COUNT: rdata_q <= {{(32-CNT_W){1'b0}}, rif.count};
                default: rdata_q <= '0;
            endcase
        end else if (s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    a_bresp_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
        bvalid_q && !s_axi_bready_in |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped before bready");
endmodule

// ### verilog/pprx_receiver.sv
// Purpose: printer side receiver of the strobed 8-bit parallel host port
// Assumes: all host pins asynchronous, status inputs on clk_in
// Notes: bytes leave through a valid/ready handover to the input buffer
// What this block does
// - strobe idles high; a falling strobe starts taking in a byte
// - eight data lines carry one byte; a high line is a one
// - once the byte is taken and space exists, ack pulses low 10 us
// - ack and busy come as a pair; busy drops when ack ends unless off line or in error
// - busy high while taking a byte, off line, or in error
// - paper-empty output high exactly while paper is out
// - error output low while paper out, off line or faulty
// - while initialise is low every strobe is ignored
// - auto-feed mode sampled at power-on and panel init, polarity selectable
// - flow codes honoured per select-in level, sampled at power-on only
`timescale 1ns/1ps
module pprx_receiver #(
    parameter int ACK_CYCLES = pprx_pkg::ACK_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [pprx_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [pprx_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic strobe_n_in,
    input wire logic [pprx_pkg::BYTE_W-1:0] parallel_byte_lines_in,
    input wire logic init_n_in,
    input wire logic autofeed_in,
    input wire logic select_in_gate_in,
    output logic byte_accepted_pulse_n_out,
    output logic busy_out,
    output logic paper_empty_flag_out,
    output logic error_n_out,
    output logic select_out_line_out,
    input wire logic offline_in,
    input wire logic paper_out_in,
    input wire logic fault_in,
    input wire logic panel_init_in,
    output logic [pprx_pkg::BYTE_W-1:0] rx_byte_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic auto_feed_on_cr_out,
    output logic flow_codes_enable_out
);
    import pprx_pkg::*;
    localparam int PIN_W = BYTE_W + 4;
    localparam logic [ACK_CW-1:0] ACK_LAST = ACK_CW'(ACK_CYCLES - 1);

    pprx_if rif ();

    pprx_axil_regs u_regs (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .s_axi_awaddr_in(s_axi_awaddr_in),
        .s_axi_awvalid_in(s_axi_awvalid_in),
        .s_axi_awready_out(s_axi_awready_out),
        .s_axi_wdata_in(s_axi_wdata_in),
        .s_axi_wstrb_in(s_axi_wstrb_in),
        .s_axi_wvalid_in(s_axi_wvalid_in),
        .s_axi_wready_out(s_axi_wready_out),
        .s_axi_bresp_out(s_axi_bresp_out),
        .s_axi_bvalid_out(s_axi_bvalid_out),
        .s_axi_bready_in(s_axi_bready_in),
        .s_axi_araddr_in(s_axi_araddr_in),
        .s_axi_arvalid_in(s_axi_arvalid_in),
        .s_axi_arready_out(s_axi_arready_out),
        .s_axi_rdata_out(s_axi_rdata_out),
        .s_axi_rresp_out(s_axi_rresp_out),
        .s_axi_rvalid_out(s_axi_rvalid_out),
        .s_axi_rready_in(s_axi_rready_in),
        .rif(rif.regs)
    );

    logic [PIN_W-1:0] pin_meta_q, pin_sync_q;
    logic [BYTE_W-1:0] byte_s, byte_q;
    logic strobe_s, init_s, af_s, si_s, strobe_prev_q;
    logic strobe_fall, init_active, blocked, take, handed;
    pprx_state_t state_q;
    logic [ACK_CW-1:0] ack_cnt_q;
    logic [CNT_W-1:0] count_q;
    logic [1:0] pwr_cnt_q;
    logic pwr_done_q, pwr_sample, af_sample;
    logic auto_feed_q, flow_q;

    // two-flop synchroniser for every host pin
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_meta_q <= '1;
            pin_sync_q <= '1;
        end else begin
            pin_meta_q <= {select_in_gate_in, autofeed_in, init_n_in, strobe_n_in,
                parallel_byte_lines_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign byte_s = pin_sync_q[BYTE_W-1:0];
    assign strobe_s = pin_sync_q[BYTE_W];
    assign init_s = pin_sync_q[BYTE_W+1];
    assign af_s = pin_sync_q[BYTE_W+2];
    assign si_s = pin_sync_q[BYTE_W+3];

    // falling edge of the synchronised strobe
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            strobe_prev_q <= 1'b1;
        end else begin
            strobe_prev_q <= strobe_s;
        end
    end

    assign strobe_fall = strobe_prev_q && !strobe_s;
    assign init_active = !init_s;
    assign blocked = offline_in || fault_in || paper_out_in || rif.ctrl[CTRL_OFFL];
    assign take = (state_q == S_IDLE) && strobe_fall && !init_active && !blocked;
    assign handed = (state_q == S_HAND) && rx_ready_in;

    // take, hand over, acknowledge
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= S_IDLE;
            ack_cnt_q <= '0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (take) begin
                        state_q <= S_HAND;
                    end
                end
                S_HAND: begin
                    if (rx_ready_in) begin
                        state_q <= S_ACK;
                        ack_cnt_q <= '0;
                    end
                end
                S_ACK: begin
                    if (ack_cnt_q == ACK_LAST) begin
                        state_q <= S_IDLE;
                    end else begin
                        ack_cnt_q <= ack_cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // byte latch and handed-over count
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            byte_q <= '0;
            count_q <= '0;
        end else begin
            if (take) begin
                byte_q <= byte_s;
            end
            if (handed) begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // power-on and panel-init sampling of the mode pins
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pwr_cnt_q <= '0;
            pwr_done_q <= 1'b0;
        end else if (!pwr_done_q) begin
            pwr_cnt_q <= pwr_cnt_q + 1'b1;
            pwr_done_q <= (pwr_cnt_q == PWR_SAMPLE_AT);
        end
    end

    assign pwr_sample = !pwr_done_q && (pwr_cnt_q == PWR_SAMPLE_AT);
    assign af_sample = pwr_sample || panel_init_in;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            auto_feed_q <= 1'b0;
            flow_q <= 1'b0;
        end else begin
            if (af_sample) begin
                auto_feed_q <= (af_s == rif.ctrl[CTRL_AF_POL]);
            end
            if (pwr_sample) begin
                flow_q <= (si_s == rif.ctrl[CTRL_SI_POL]);
            end
        end
    end

    assign rx_byte_out = byte_q;
    assign rx_valid_out = (state_q == S_HAND);
    assign byte_accepted_pulse_n_out = (state_q != S_ACK);
    assign busy_out = (state_q != S_IDLE) || blocked;
    assign paper_empty_flag_out = paper_out_in;
    assign error_n_out = !(paper_out_in || offline_in || fault_in);
    assign select_out_line_out = 1'b1;
    assign auto_feed_on_cr_out = auto_feed_q;
    assign flow_codes_enable_out = flow_q;

    assign rif.last_byte = byte_q;
    assign rif.count = count_q;
    assign rif.status = {state_q == S_HAND, init_active, flow_q, auto_feed_q,
        !error_n_out, paper_out_in, state_q == S_ACK, busy_out};

    // checks
    logic [ACK_CW-1:0] ack_run_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ack_run_q <= '0;
        end else if (!byte_accepted_pulse_n_out) begin
            ack_run_q <= ack_run_q + 1'b1;
        end else begin
            ack_run_q <= '0;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_ack_width: assert property (
        $rose(byte_accepted_pulse_n_out) |-> ack_run_q == ACK_LAST + 1'b1)
        else $error("ack low time wrong");
    a_ack_after_hand: assert property (
        rx_valid_out && rx_ready_in |=> !byte_accepted_pulse_n_out)
        else $error("ack did not start after handover");
    a_busy_pairs_ack: assert property (
        !byte_accepted_pulse_n_out |-> busy_out)
        else $error("ack without busy");
    a_busy_release: assert property (
        $rose(byte_accepted_pulse_n_out) |-> busy_out == blocked)
        else $error("busy not released with ack end");
    a_busy_causes: assert property (
        (offline_in || fault_in) |-> busy_out)
        else $error("busy low while off line or faulty");
    a_take_busy: assert property (
        take |=> busy_out && rx_valid_out)
        else $error("byte taken without busy");
    a_paper_flag: assert property (
        paper_out_in |-> paper_empty_flag_out && !error_n_out)
        else $error("paper out not flagged");
    a_error_level: assert property (
        error_n_out |-> !(offline_in || fault_in || paper_out_in))
        else $error("error line high in error");
    a_init_ignore: assert property (
        state_q == S_IDLE && init_active |=> !rx_valid_out)
        else $error("strobe taken during initialise");
    a_capture_byte: assert property (
        take |=> rx_byte_out == $past(byte_s) && rx_valid_out)
        else $error("captured byte differs from lines");
    a_byte_hold: assert property (
        rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_byte_out))
        else $error("handover byte not held");
    a_flow_stable: assert property (
        !pwr_sample |=> $stable(flow_codes_enable_out))
        else $error("flow mode changed outside power-on");
    a_autofeed_stable: assert property (
        !af_sample |=> $stable(auto_feed_on_cr_out))
        else $error("auto-feed mode changed without sampling");
    a_ack_source: assert property (
        $fell(byte_accepted_pulse_n_out) |-> $past(handed))
        else $error("ack started without handover");
    a_busy_paper: assert property (
        (paper_out_in || rif.ctrl[CTRL_OFFL]) |-> busy_out)
        else $error("busy low while paper out or forced off line");
    a_idle_free: assert property (
        !busy_out |-> byte_accepted_pulse_n_out && !rx_valid_out)
        else $error("busy low while a byte is in progress");
    a_error_when: assert property (
        (offline_in || fault_in || paper_out_in) |-> !error_n_out)
        else $error("error line high during an error condition");
    a_count_step: assert property (
        handed |=> count_q == $past(count_q) + 1'b1)
        else $error("handover count did not step");
    a_pwr_once: assert property (
        pwr_done_q |=> pwr_done_q && !pwr_sample)
        else $error("power-on sample repeated");
    a_hand_from_take: assert property (
        $rose(rx_valid_out) |-> $past(take))
        else $error("handover started without a take");

    c_byte_done: cover property (take ##[1:20] handed);
    c_ack_end: cover property ($rose(byte_accepted_pulse_n_out));
    c_init_block: cover property (state_q == S_IDLE && strobe_fall && init_active);
    c_offline: cover property (strobe_fall && blocked);
    c_panel_sample: cover property (panel_init_in && af_sample);
endmodule
